/* rtl/nand_host_defines.svh */
`ifndef NAND_HOST_DEFINES_SVH
`define NAND_HOST_DEFINES_SVH

// Clock and derived strobe timing
`define CLK_PERIOD_NS 10
`define NS2CYC(ns)    (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_SETUP_NS    12
`define T_PULSE_NS    12
`define T_ACCESS_NS   20
`define T_HOLD_NS     10
`define T_TURN_NS     60
`define T_WB_NS       100
`define SYNC_STAGES   2
`define SETUP_CYC     4'(`NS2CYC(`T_SETUP_NS))
`define LOW_CYC       4'(`NS2CYC(`T_PULSE_NS))
`define READ_LOW_CYC  4'(`NS2CYC(`T_ACCESS_NS) + `SYNC_STAGES + 1)
`define HOLD_CYC      4'(`NS2CYC(`T_HOLD_NS))
`define TURN_CYC      4'(`NS2CYC(`T_TURN_NS))
`define WB_CYC        4'(`NS2CYC(`T_WB_NS))

// Register byte offsets
`define REG_CTRL      5'h00
`define REG_STATUS    5'h04
`define REG_COLUMN    5'h08
`define REG_PAGE      5'h0C
`define REG_GUARD     5'h10

// Field layout and reset values
`define CTRL_OP_LSB   8
`define STAT_DATA_LSB 8
`define COL_LAST      13'h10FF
`define BLK_LSB       6
`define GUARD_RST     2'h2

// Commands accepted while the device is busy
`define CMD_STATUS    8'h70
`define CMD_STATUS_MP 8'h71
`define CMD_RESET     8'hFF

`endif

/* rtl/nand_host_pkg.sv */
package nand_host_pkg;
  typedef enum logic [2:0] {
    OP_CMD   = 3'h0,
    OP_ADDR5 = 3'h1,
    OP_ADDR2 = 3'h2,
    OP_ROW   = 3'h3,
    OP_DIN   = 3'h4,
    OP_DOUT  = 3'h5,
    OP_WAIT  = 3'h6
  } op_t;
  typedef enum logic [1:0] {
    K_CMD  = 2'h0,
    K_ADDR = 2'h1,
    K_DIN  = 2'h2,
    K_DOUT = 2'h3
  } cyc_kind_t;
  typedef enum logic [1:0] {
    S_IDLE   = 2'b00,
    S_RUN    = 2'b01,
    S_SETTLE = 2'b11,
    S_WAIT   = 2'b10
  } eng_st_t;
  typedef enum logic [2:0] {
    P_IDLE  = 3'b000,
    P_SETUP = 3'b001,
    P_LOW   = 3'b011,
    P_HOLD  = 3'b010,
    P_GAP   = 3'b110
  } ph_t;
endpackage

/* rtl/strobe_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface strobe_if;
  import nand_host_pkg::*;
  logic      req;
  cyc_kind_t kind;
  logic [7:0] wbyte;
  logic      done;
  logic [7:0] rbyte;
  modport ctl (output req, kind, wbyte, input done, rbyte);
  modport eng (input req, kind, wbyte, output done, rbyte);
endinterface
`default_nettype wire

/* rtl/nand_strobe_unit.sv */
`timescale 1ns/10ps
`default_nettype none
`include "nand_host_defines.svh"
module nand_strobe_unit (
  // Clock and reset
  input  wire logic  clk,
  input  wire logic  rst,
  // Cycle requests
  strobe_if.eng      sb,
  // Device pins
  output logic       command_latch_strobe,
  output logic       address_latch_strobe,
  output logic       write_strobe_n,
  output logic       read_strobe_n,
  output logic [7:0] shared_io_bus_out,
  output logic       shared_io_bus_oe,
  input  wire logic [7:0] shared_io_bus_in
);
  import nand_host_pkg::*;

  typedef struct packed {
    ph_t        ph;
    logic [3:0] cnt;
    cyc_kind_t  kind;
    logic       cle;
    logic       ale;
    logic       we_n;
    logic       re_n;
    logic       oe;
    logic       done;
    logic [7:0] dout;
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] rbyte;
  } stb_t;

  stb_t q;
  stb_t n;

  always_comb begin
    n = q;
    n.done = 1'b0;
    n.s1 = shared_io_bus_in;
    n.s2 = q.s1;
    unique case (q.ph)
      P_IDLE: if (sb.req) begin
        // Latch lines settle before the strobe falls
        n.kind = sb.kind;
        n.cle = (sb.kind == K_CMD);  // see RQ7
        n.ale = (sb.kind == K_ADDR);  // see RQ7
        n.oe = (sb.kind != K_DOUT);
        n.dout = sb.wbyte;
        n.cnt = `SETUP_CYC - 4'h1;
        n.ph = P_SETUP;
      end
      P_SETUP: if (q.cnt != 4'h0) begin
        n.cnt = q.cnt - 4'h1;
      end else if (q.kind == K_DOUT) begin
        n.re_n = 1'b0;  // see RQ4
        n.cnt = `READ_LOW_CYC - 4'h1;
        n.ph = P_LOW;
      end else begin
        n.we_n = 1'b0;
        n.cnt = `LOW_CYC - 4'h1;
        n.ph = P_LOW;
      end
      P_LOW: if (q.cnt != 4'h0) begin
        n.cnt = q.cnt - 4'h1;
      end else begin
        // Rising write strobe latches the byte in the device
        n.we_n = 1'b1;  // see RQ1 and RQ2
        n.re_n = 1'b1;
        if (q.kind == K_DOUT) begin
          n.rbyte = q.s2;
        end
        n.cnt = `HOLD_CYC - 4'h1;
        n.ph = P_HOLD;
      end
      P_HOLD: if (q.cnt != 4'h0) begin
        n.cnt = q.cnt - 4'h1;
      end else begin
        n.cle = 1'b0;
        n.ale = 1'b0;
        n.oe = 1'b0;
        n.cnt = `TURN_CYC - 4'h1;
        n.ph = P_GAP;
      end
      P_GAP: if (q.cnt != 4'h0) begin
        n.cnt = q.cnt - 4'h1;
      end else begin
        n.done = 1'b1;
        n.ph = P_IDLE;
      end
      default: n.ph = P_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
      q.we_n <= 1'b1;
      q.re_n <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign command_latch_strobe = q.cle;
  assign address_latch_strobe = q.ale;
  assign write_strobe_n       = q.we_n;
  assign read_strobe_n        = q.re_n;
  assign shared_io_bus_out    = q.dout;
  assign shared_io_bus_oe     = q.oe;
  assign sb.done              = q.done;
  assign sb.rbyte             = q.rbyte;

  latch_excl_a: assert property (@(posedge clk) disable iff (rst)  // see RQ7
    !(q.cle && q.ale) && !(!q.we_n && !q.re_n))
    else $error("latch strobes or read and write strobes overlap");
  write_pulse_a: assert property (@(posedge clk) disable iff (rst)  // see RQ1
    $fell(q.we_n) |-> (q.cle || q.ale || q.oe) ##1 !q.we_n ##1 q.we_n)
    else $error("write strobe low time wrong or lines undriven");
  read_pulse_a: assert property (@(posedge clk) disable iff (rst)  // see RQ4
    $fell(q.re_n) |-> !q.oe ##4 !q.re_n ##1 q.re_n)
    else $error("read strobe low time wrong or bus driven");
endmodule
`default_nettype wire

/* rtl/nand_host_ctrl.sv */
// Contract
// RQ1: Command byte latched on write strobe rise
// RQ2: Address byte latched on write strobe rise
// RQ3: Select high while ready gives standby
// RQ4: Each read strobe fall outputs next byte
// RQ5: Low guard refuses program and erase
// RQ6: Ready line low during array operations
// RQ7: Strobe levels select the cycle type
// RQ8: Strobes stay high during busy periods
// RQ9: Only status and reset accepted while busy
// RQ10: Five address bytes: column, then page
// RQ11: Page index splits into block, page
// RQ12: Page 4352 bytes, 64 pages, 2048 blocks
// RQ13: Program by page, erase by block
// RQ14: Read is 00h, address, 30h
// RQ15: After power-on read set-up preselected
// RQ16: Output column change: 05h, column, E0h
// RQ17: Input column change: 85h, new column
// RQ18: Cache read with 31h, last with 3Fh
// RQ19: Program 80h, data, 10h or 15h
// RQ20: Multi-plane 80h..11h then 81h..10h/15h
// RQ21: After 15h end, poll status then reset
// RQ22: Copy 00h-3Ah, 8Ch; erase 60h-D0h; ID 90h
`timescale 1ns/10ps
`default_nettype none
`include "nand_host_defines.svh"
module nand_host_ctrl (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Avalon-MM slave
  input  wire logic [4:0]  av_address,
  input  wire logic        av_read,
  input  wire logic        av_write,
  input  wire logic [31:0] av_writedata,
  input  wire logic [3:0]  av_byteenable,
  output logic [31:0]      av_readdata,
  output logic             av_waitrequest,
  // Device pins
  output logic             command_latch_strobe,
  output logic             address_latch_strobe,
  output logic             device_select_n,
  output logic             write_strobe_n,
  output logic             read_strobe_n,
  output logic             program_guard_n,
  output logic [7:0]       shared_io_bus_out,
  output logic             shared_io_bus_oe,
  input  wire logic [7:0]  shared_io_bus_in,
  input  wire logic        ready_busy_n
);
  import nand_host_pkg::*;

  typedef struct packed {
    eng_st_t     st;
    op_t         op;
    logic [7:0]  cbyte;
    logic [2:0]  idx;
    logic [2:0]  last;
    logic [3:0]  cnt;
    logic [12:0] col;
    logic [16:0] page;
    logic        pg;
    logic        sel_n;
    logic        refused;
    logic        stat;
    logic [7:0]  rdata;
    logic        req;
    cyc_kind_t   kind;
    logic [7:0]  wbyte;
    logic        rdy1;
    logic        rdy2;
    logic        wreq;
    logic [31:0] rd;
  } eng_t;

  eng_t q;
  eng_t n;

  strobe_if sb ();

  function automatic logic [31:0] be_merge(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Byte of the five-cycle address for cycle index i
  function automatic logic [7:0] addr_byte(input logic [2:0]  i,
                                           input logic [12:0] c,
                                           input logic [16:0] p);
    case (i)
      3'd0:    return c[7:0];
      3'd1:    return {3'h0, c[12:8]};  // see RQ10
      3'd2:    return p[7:0];
      3'd3:    return p[15:8];
      default: return {7'h0, p[16]};  // see RQ10
    endcase
  endfunction

  logic [31:0] m;
  logic [16:0] pg_eff;
  logic        go;
  logic        busy_ok;

  always_comb begin
    n = q;
    m = '0;
    go = 1'b0;
    n.req = 1'b0;
    n.rdy1 = ready_busy_n;
    n.rdy2 = q.rdy1;
    if (!q.wreq) begin
      // A write lands on the edge at which the master sees the answer
      n.wreq = 1'b1;
      if (av_write) begin
        unique case (av_address)
          `REG_CTRL: begin
            n.op = op_t'(av_writedata[`CTRL_OP_LSB +: 3]);
            n.cbyte = av_writedata[7:0];
            n.refused = 1'b0;
            go = 1'b1;
          end
          `REG_COLUMN: begin
            m = be_merge({19'h0, q.col}, av_writedata, av_byteenable);
            n.col = m[12:0];
          end
          `REG_PAGE: begin
            m = be_merge({15'h0, q.page}, av_writedata, av_byteenable);
            n.page = m[16:0];
          end
          `REG_GUARD: if (av_byteenable[0]) begin
            n.pg = av_writedata[0];  // see RQ5
            n.sel_n = av_writedata[1];  // see RQ3
          end
          default: go = 1'b0;
        endcase
      end
    end else if (av_read) begin
      n.wreq = 1'b0;
      unique case (av_address)
        `REG_CTRL:   n.rd = {21'h0, q.op, q.cbyte};
        `REG_STATUS: n.rd = {16'h0, q.rdata, 4'h0, q.stat, q.refused,
                             q.rdy2, q.st != S_IDLE};
        `REG_COLUMN: n.rd = {19'h0, q.col};
        `REG_PAGE:   n.rd = {15'h0, q.page};
        `REG_GUARD:  n.rd = {30'h0, q.sel_n, q.pg};
        default:     n.rd = '0;
      endcase
    end else if (av_write) begin
      // A new order stalls the bus until the engine is idle
      n.rd = '0;
      n.wreq = (av_address == `REG_CTRL) && (q.st != S_IDLE);
    end

    // Row-only addressing drops the page-in-block bits
    pg_eff = (n.op == OP_ROW) ?
             {n.page[16:`BLK_LSB], `BLK_LSB'(0)} : n.page;  // see RQ11 and RQ13
    busy_ok = q.rdy2;
    unique case (q.st)
      S_IDLE: if (go) begin
        n.st = S_RUN;
        n.req = 1'b1;
        n.idx = 3'd0;
        n.last = 3'd0;
        case (n.op)
          OP_CMD: begin
            n.kind = K_CMD;
            n.wbyte = n.cbyte;  // see RQ18, RQ19, RQ20 and RQ22
            n.stat = (n.cbyte == `CMD_STATUS) || (n.cbyte == `CMD_STATUS_MP);
            busy_ok = q.rdy2 || n.stat || (n.cbyte == `CMD_RESET);  // see RQ9
          end
          OP_ADDR5, OP_ADDR2, OP_ROW: begin
            n.kind = K_ADDR;
            n.idx = (n.op == OP_ROW) ? 3'd2 : 3'd0;
            n.last = (n.op == OP_ADDR2) ? 3'd1 : 3'd4;  // see RQ16 and RQ17
            n.wbyte = addr_byte(n.idx, q.col, pg_eff);
            busy_ok = q.rdy2 && (q.col <= `COL_LAST);  // see RQ12
          end
          OP_DIN: begin
            n.kind = K_DIN;
            busy_ok = q.rdy2 && q.pg;  // see RQ5
            n.wbyte = n.cbyte;
          end
          OP_DOUT: begin
            n.kind = K_DOUT;
            busy_ok = q.rdy2 || q.stat;  // see RQ21
          end
          OP_WAIT: begin
            // Waiting for ready is the one order that never needs ready
            busy_ok = 1'b1;
            n.req = 1'b0;
            n.st = S_SETTLE;
            n.cnt = `WB_CYC - 4'h1;
          end
          default: busy_ok = 1'b0;
        endcase
        // Refused orders touch no pin while the device is busy
        if (!busy_ok) begin  // see RQ8
          n.req = 1'b0;
          n.st = S_IDLE;
          n.refused = 1'b1;
        end
      end
      S_RUN: if (sb.done) begin
        if (q.kind == K_ADDR && q.idx != q.last) begin
          n.idx = q.idx + 3'd1;
          n.wbyte = addr_byte(n.idx, q.col, pg_eff);  // see RQ10
          n.req = 1'b1;
        end else if (q.kind == K_CMD) begin
          // Give the device time to pull its ready line low
          n.st = S_SETTLE;  // see RQ6 and RQ14
          n.cnt = `WB_CYC - 4'h1;
        end else begin
          if (q.kind == K_DOUT) begin
            n.rdata = sb.rbyte;  // see RQ4
          end
          n.st = S_IDLE;
        end
      end
      S_SETTLE: if (q.cnt != 4'h0) begin
        n.cnt = q.cnt - 4'h1;
      end else begin
        n.st = (q.op == OP_WAIT) ? S_WAIT : S_IDLE;
      end
      S_WAIT: if (q.rdy2) begin
        n.st = S_IDLE;  // see RQ6
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
      q.wreq <= 1'b1;
      {q.sel_n, q.pg} <= `GUARD_RST;
    end else begin
      q <= n;
    end
  end

  assign sb.req = q.req;
  assign sb.kind = q.kind;
  assign sb.wbyte = q.wbyte;

  nand_strobe_unit strobe (
    .clk                  (clk),
    .rst                  (rst),
    .sb                   (sb),
    .command_latch_strobe (command_latch_strobe),
    .address_latch_strobe (address_latch_strobe),
    .write_strobe_n       (write_strobe_n),
    .read_strobe_n        (read_strobe_n),
    .shared_io_bus_out    (shared_io_bus_out),
    .shared_io_bus_oe     (shared_io_bus_oe),
    .shared_io_bus_in     (shared_io_bus_in)
  );

  assign av_readdata     = q.rd;
  assign av_waitrequest  = q.wreq;
  assign device_select_n = q.sel_n;
  assign program_guard_n = q.pg;

  busy_cmd_a: assert property (@(posedge clk) disable iff (rst)  // see RQ9
    q.req && q.kind == K_CMD && !q.rdy2 |->
      q.wbyte inside {`CMD_STATUS, `CMD_STATUS_MP, `CMD_RESET})
    else $error("command other than status or reset issued while busy");
  busy_strobe_a: assert property (@(posedge clk) disable iff (rst)  // see RQ8
    q.req && q.kind != K_CMD |-> q.rdy2 || (q.kind == K_DOUT && q.stat))
    else $error("strobe cycle started while device busy");
  addr_layout_a: assert property (@(posedge clk) disable iff (rst)  // see RQ10
    q.req && q.kind == K_ADDR |->
      (q.idx != 3'd1 || q.wbyte[7:5] == 3'h0) &&
      (q.idx != 3'd4 || q.wbyte[7:1] == 7'h0))
    else $error("address byte upper bits not low");
  guard_din_a: assert property (@(posedge clk) disable iff (rst)  // see RQ5
    q.req && q.kind == K_DIN |-> program_guard_n ##1 q.st == S_RUN)
    else $error("data input issued with guard low");
  settle_time_a: assert property (@(posedge clk) disable iff (rst)  // see RQ6
    $rose(q.st == S_SETTLE) |-> (q.st == S_SETTLE) [*8] ##1
      q.st == S_SETTLE ##1 q.st == S_SETTLE)
    else $error("busy settle shorter than required");
  ctrl_stall_a: assert property (@(posedge clk) disable iff (rst)
    av_write && av_address == `REG_CTRL && q.st != S_IDLE && q.wreq
      |=> av_waitrequest)
    else $error("order accepted while engine active");
endmodule
`default_nettype wire

/* testbench/nand_dev_model.sv */
`timescale 1ns/10ps
`default_nettype none
module nand_dev_model #(
  parameter logic [7:0] BUSY = 8'hC8
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Device pins
  input  wire logic        command_latch_strobe,
  input  wire logic        address_latch_strobe,
  input  wire logic        device_select_n,
  input  wire logic        write_strobe_n,
  input  wire logic        read_strobe_n,
  input  wire logic        program_guard_n,
  input  wire logic [7:0]  io,
  output logic [7:0]       q,
  output logic             q_oe,
  output logic             ready_busy_n,
  // Observation
  output logic             standby,
  output logic [7:0]       cmd_r,
  output logic [12:0]      col_r,
  output logic [16:0]      page_r,
  output logic [7:0]       starts,
  output logic [7:0]       err_cnt
);
  logic [7:0] busy_cnt;
  logic [2:0] acnt;
  logic       we_q, rs_q, wr, rd, stat, go;
  assign ready_busy_n = (busy_cnt == 8'h00);
  assign q_oe = !device_select_n && !read_strobe_n;
  assign wr = !device_select_n && write_strobe_n && !we_q;
  assign rd = !device_select_n && !read_strobe_n && rs_q;
  assign stat = (cmd_r == 8'h70) || (cmd_r == 8'h71);
  assign go = (io == 8'h10 || io == 8'hD0) && program_guard_n;
  always @(posedge clk) begin
    we_q <= write_strobe_n;
    rs_q <= read_strobe_n;
    if (rst) begin
      busy_cnt <= 8'h00;
      cmd_r    <= 8'h00;
      acnt     <= 3'h0;
      starts   <= 8'h00;
      err_cnt  <= 8'h00;
      standby  <= 1'b0;
      q        <= 8'h00;
      col_r    <= 13'h0;
      page_r   <= 17'h0;
    end else begin
      if (busy_cnt != 8'h00) busy_cnt <= busy_cnt - 8'h01;
      if (device_select_n) begin
        if (ready_busy_n) standby <= 1'b1;
      end else standby <= 1'b0;
      if (wr && command_latch_strobe) begin
        cmd_r <= io;
        acnt <= (io == 8'h60) ? 3'h2 : 3'h0;
        if (!ready_busy_n && io != 8'h70 && io != 8'h71 && io != 8'hFF)
          err_cnt <= err_cnt + 8'h01;
        if ((io == 8'h30 && cmd_r == 8'h00) || go) begin
          busy_cnt <= BUSY;
          starts <= starts + 8'h01;
        end
        if (io == 8'hFF) busy_cnt <= 8'h14;
      end
      if (wr && address_latch_strobe) begin
        acnt <= acnt + 3'h1;
        case (acnt)
          3'h0: col_r[7:0] <= io;
          3'h1: col_r[12:8] <= io[4:0];
          3'h2: page_r[7:0] <= io;
          3'h3: page_r[15:8] <= io;
          default: page_r[16] <= io[0];
        endcase
        if ((acnt == 3'h1 && io[7:5] != 3'h0) || (acnt == 3'h4 && io[7:1] != 7'h0))
          err_cnt <= err_cnt + 8'h01;
      end
      if (rd) begin
        q <= stat ? {program_guard_n, {2{ready_busy_n}}, 5'h00}
                  : col_r[7:0] ^ page_r[7:0];
        col_r <= col_r + 13'h1;
        if (!ready_busy_n && !stat) err_cnt <= err_cnt + 8'h01;
      end
      if (!write_strobe_n && !read_strobe_n) err_cnt <= err_cnt + 8'h01;
    end
  end
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "nand_host_defines.svh"
module tb_top;
  import nand_host_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [4:0]  av_address = 5'h00;
  logic        av_read = 1'b0;
  logic        av_write = 1'b0;
  logic [31:0] av_writedata = 32'h0;
  logic [31:0] av_readdata, st;
  logic        av_waitrequest, cle, ale, sel_n, wr_n, rd_n, guard_n;
  logic        host_oe, dq_oe, ready_busy_n, standby;
  logic [7:0]  host_q, dq, io_in, cmd_r, starts, err_cnt;
  logic [7:0]  last_io = 8'h00;
  logic [12:0] col_r;
  logic [16:0] page_r;
  int          fail_count = 0;
  int          num_checks = 0;

  // Released bus shows a level that changes every cycle
  assign io_in = host_oe ? host_q : (dq_oe ? dq : ~last_io);
  always @(posedge clk) last_io <= io_in;

  nand_host_ctrl dut (.clk(clk), .rst(rst), .av_address(av_address),
    .av_read(av_read), .av_write(av_write), .av_writedata(av_writedata),
    .av_byteenable(4'hF), .av_readdata(av_readdata),
    .av_waitrequest(av_waitrequest), .command_latch_strobe(cle),
    .address_latch_strobe(ale), .device_select_n(sel_n),
    .write_strobe_n(wr_n), .read_strobe_n(rd_n), .program_guard_n(guard_n),
    .shared_io_bus_out(host_q), .shared_io_bus_oe(host_oe),
    .shared_io_bus_in(io_in), .ready_busy_n(ready_busy_n));

  nand_dev_model dev (.clk(clk), .rst(rst), .command_latch_strobe(cle),
    .address_latch_strobe(ale), .device_select_n(sel_n),
    .write_strobe_n(wr_n), .read_strobe_n(rd_n), .program_guard_n(guard_n),
    .io(io_in), .q(dq), .q_oe(dq_oe), .ready_busy_n(ready_busy_n),
    .standby(standby), .cmd_r(cmd_r), .col_r(col_r), .page_r(page_r),
    .starts(starts), .err_cnt(err_cnt));

  initial begin
    forever #5 clk = ~clk;
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic av(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    av_address <= a;
    av_writedata <= d;
    av_read <= !w;
    av_write <= w;
    do begin
      @(posedge clk);
    end while (av_waitrequest !== 1'b0);
    st = av_readdata;
    av_read <= 1'b0;
    av_write <= 1'b0;
  endtask

  task automatic op(input op_t o, input logic [7:0] b);
    av(1'b1, `REG_CTRL, {21'h0, o, b});
    do begin
      av(1'b0, `REG_STATUS, 32'h0);
    end while (st[0] !== 1'b0);
  endtask

  task automatic t_reset;
    av(1'b0, `REG_GUARD, 32'h0);
    chk("guard reg", 32'h2, st);
    av(1'b0, 5'h14, 32'h0);
    chk("unmapped", 32'h0, st);
    chk("guard pin", 1'b0, guard_n);
    chk("standby", 1'b1, standby);
    $display("reset test done");
  endtask

  task automatic t_read;
    av(1'b1, `REG_GUARD, 32'h1);
    av(1'b1, `REG_COLUMN, 32'h105);
    av(1'b1, `REG_PAGE, 32'h14043);
    op(OP_ADDR5, 8'h00);
    op(OP_CMD, 8'h30);
    chk("column", 13'h105, col_r);
    chk("page", 17'h14043, page_r);
    chk("starts", 8'h01, starts);
    op(OP_WAIT, 8'h00);
    op(OP_DOUT, 8'h00);
    chk("byte0", 8'h46, st[15:8]);
    op(OP_DOUT, 8'h00);
    chk("byte1", 8'h45, st[15:8]);
    $display("read test done");
  endtask

  task automatic t_busy;
    op(OP_CMD, 8'h00);
    op(OP_ADDR5, 8'h00);
    op(OP_CMD, 8'h30);
    op(OP_CMD, 8'h80);
    chk("refused", 1'b1, st[2]);
    chk("cmd held", 8'h30, cmd_r);
    av(1'b1, `REG_GUARD, 32'h3);
    repeat (2) @(posedge clk);
    chk("no standby", 1'b0, standby);
    av(1'b1, `REG_GUARD, 32'h1);
    op(OP_CMD, 8'h70);
    chk("status ok", 1'b0, st[2]);
    op(OP_DOUT, 8'h00);
    chk("status byte", 8'h80, st[15:8]);
    op(OP_WAIT, 8'h00);
    chk("ready", 1'b1, st[1]);
    $display("busy test done");
  endtask

  task automatic t_prog;
    logic [7:0] s0;
    s0 = starts;
    av(1'b1, `REG_GUARD, 32'h0);
    @(posedge clk);
    chk("guard low", 1'b0, guard_n);
    op(OP_CMD, 8'h80);
    op(OP_ADDR5, 8'h00);
    op(OP_DIN, 8'h5A);
    chk("din refused", 1'b1, st[2]);
    op(OP_CMD, 8'h10);
    chk("no program", s0, starts);
    av(1'b1, `REG_GUARD, 32'h1);
    op(OP_CMD, 8'h80);
    av(1'b1, `REG_COLUMN, 32'h1100);
    op(OP_ADDR5, 8'h00);
    chk("col refused", 1'b1, st[2]);
    av(1'b1, `REG_COLUMN, 32'h10FF);
    op(OP_ADDR5, 8'h00);
    chk("last col", 13'h10FF, col_r);
    op(OP_DIN, 8'hA5);
    op(OP_CMD, 8'h10);
    chk("program", s0 + 8'h01, starts);
    op(OP_WAIT, 8'h00);
    $display("program test done");
  endtask

  task automatic t_erase;
    logic [7:0] s0;
    s0 = starts;
    av(1'b1, `REG_PAGE, 32'h1FFFF);
    op(OP_CMD, 8'h60);
    op(OP_ROW, 8'h00);
    op(OP_CMD, 8'hD0);
    chk("block", 17'h1FFC0, page_r);
    chk("erase", s0 + 8'h01, starts);
    // An order written while the engine waits must stall until ready
    av(1'b1, `REG_CTRL, {21'h0, OP_WAIT, 8'h00});
    op(OP_CMD, 8'h70);
    chk("queued order", 32'h2, st & 32'h7);
    chk("queued code", 8'h70, cmd_r);
    $display("erase test done");
  endtask

  task automatic t_codes;
    logic [7:0] c [12] = '{8'h90, 8'h31, 8'h3F, 8'h05, 8'hE0, 8'h85,
                           8'h3A, 8'h8C, 8'h11, 8'h81, 8'h15, 8'h71};
    foreach (c[i]) begin
      op(OP_CMD, c[i]);
      chk("code", c[i], cmd_r);
    end
    op(OP_CMD, 8'hFF);
    op(OP_WAIT, 8'h00);
    chk("after reset", 1'b1, ready_busy_n);
    $display("codes test done");
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_read();
    t_busy();
    t_prog();
    t_erase();
    t_codes();
    chk("model errors", 8'h00, err_cnt);
    print_verdict();
  end

  initial begin
    repeat (60000) @(posedge clk);
    fail_count++;
    print_verdict();
  end
endmodule
`default_nettype wire
